// file: inc/pcs_pkg.sv
// Function
// R1 - In normal and delayed framing, receive bits are taken on falling main-clock edges, one per period.
// R2 - In reverse framing, receive bits are taken on rising main-clock edges.
// R3 - Receive data counts only inside the device's receive slot and is ignored outside it.
// R4 - Control bits shift in and status bits shift out on the control clock only while select is low.
// R5 - The control port runs on its own unrelated clock and crosses into the main domain safely.
// R6 - Samples are either 14-bit linear or 8-bit companded, and the port carries the chosen width.
// R7 - Framing is normal, reverse or delayed, chosen by configuration.
// R8 - Control transfers happen only while select is low; the control clock is ignored otherwise.
// R9 - Transmit bits go out on rising edges (falling in reverse) and the pin floats outside the slot.
// R10 - The far party supplies an 8 kHz frame marker that starts both frames.
// R11 - While selected, command bits are sampled on rising control-clock edges.
// R12 - While selected, status bits are shifted out on falling control-clock edges.
package pcs_pkg;
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_REVERSE = 2'h1;
  localparam logic [1:0] MODE_DELAYED = 2'h2;
  localparam int         SAMPLE_W     = 14;
  localparam int         CMP_W        = 8;
  localparam int         SHIFT_W      = 16;
  localparam logic [4:0] BITS_LIN     = 5'h10;
  localparam logic [4:0] BITS_CMP     = 5'h08;
  localparam logic [4:0] CTL_CMD_END  = 5'h08;
  localparam logic [4:0] CTL_LAST     = 5'h0f;
  localparam logic [4:0] CTL_DONE     = 5'h10;
  localparam int         CMD_RD_BIT   = 7;
  localparam logic [6:0] CFG_ADDR     = 7'h00;
  localparam logic [1:0] CFG_MODE_RST = MODE_NORMAL;
  localparam logic       CFG_LIN_RST  = 1'b1;
  localparam int         CFG_LIN_BIT  = 2;
  typedef enum logic [1:0] {
    PCM_IDLE = 2'b00,
    PCM_WAIT = 2'b01,
    PCM_SLOT = 2'b10
  } pcs_pcm_st_t;
endpackage

// file: hw/pcs_port.sv
`timescale 1ns/100ps
module pcs_port #(
  parameter int BUF_DEPTH = 2
) (
  // system
  input  wire logic                        clk_i,
  input  wire logic                        reset_n_i,
  // pcm pins
  input  wire logic                        mclk_i,
  input  wire logic                        frame_marker_i,
  input  wire logic                        receive_voice_in_i,
  output logic                             transmit_voice_out_o,
  output logic                             transmit_voice_oe_n_o,
  // control pins
  input  wire logic                        control_clock_i,
  input  wire logic                        control_select_n_i,
  input  wire logic                        command_serial_in_i,
  output logic                             status_serial_out_o,
  // receive samples
  output logic [pcs_pkg::SAMPLE_W-1:0]     rx_word_o,
  output logic                             rx_valid_o,
  input  wire logic                        rx_ready_i,
  // transmit samples
  input  wire logic [pcs_pkg::SAMPLE_W-1:0] tx_word_i,
  input  wire logic                        tx_valid_i,
  output logic                             tx_ready_o,
  // control writes to other addresses
  output logic                             ctl_wr_valid_o,
  output logic [6:0]                       ctl_wr_addr_o,
  output logic [7:0]                       ctl_wr_data_o
);
  localparam int W = pcs_pkg::SAMPLE_W;

  if (BUF_DEPTH < 2) begin : g_chk
    $error("BUF_DEPTH must be at least 2");
  end

  // pin synchronisers
  logic mc_s1_q, mc_s2_q, mc_s3_q, fs_s1_q, fs_s2_q, dr_s1_q, dr_s2_q;
  logic cs_s1_q, cs_s2_q, wt_s1_q, wt_s2_q, wt_s3_q, wt_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {mc_s1_q, mc_s2_q, mc_s3_q} <= 3'h0;
      {fs_s1_q, fs_s2_q, dr_s1_q, dr_s2_q} <= 4'h0;
      {cs_s1_q, cs_s2_q} <= 2'h3;
      {wt_s1_q, wt_s2_q, wt_s3_q} <= 3'h0;
    end else begin
      {mc_s1_q, mc_s2_q, mc_s3_q} <= {mclk_i, mc_s1_q, mc_s2_q};
      {fs_s1_q, fs_s2_q} <= {frame_marker_i, fs_s1_q};
      {dr_s1_q, dr_s2_q} <= {receive_voice_in_i, dr_s1_q};
      {cs_s1_q, cs_s2_q} <= {control_select_n_i, cs_s1_q};
      {wt_s1_q, wt_s2_q, wt_s3_q} <= {wt_q, wt_s1_q, wt_s2_q};
    end
  end

  // configuration, written over the control port
  logic [1:0] mode_q, mode_d;
  logic       lin_q, lin_d;
  logic       rev, dly, mc_rise, mc_fall, tx_edge, rx_edge;
  logic [4:0] nbits;
  assign mc_rise = mc_s2_q & ~mc_s3_q;
  assign mc_fall = ~mc_s2_q & mc_s3_q;
  assign rev     = (mode_q == pcs_pkg::MODE_REVERSE);
  assign dly     = (mode_q == pcs_pkg::MODE_DELAYED);
  assign tx_edge = rev ? mc_fall : mc_rise; // R9
  assign rx_edge = rev ? mc_rise : mc_fall; // R1 R2
  assign nbits   = lin_q ? pcs_pkg::BITS_LIN : pcs_pkg::BITS_CMP; // R6

  // pcm sequencer
  pcs_pkg::pcs_pcm_st_t st_q, st_d;
  logic [4:0]  cnt_q, cnt_d, rxc_q, rxc_d;
  logic [15:0] tsh_q, tsh_d, rsh_q, rsh_d, load;
  logic        dx_q, dx_d, oen_q, oen_d, fsp_q, fsp_d;
  logic        start, rx_take, push, take, und_set;
  logic [W-1:0] word, rx_word;
  logic        txv_q, txv_d, txr_q;
  logic [W-1:0] txw_q, txw_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    rxc_d   = rxc_q;
    tsh_d   = tsh_q;
    rsh_d   = rsh_q;
    dx_d    = dx_q;
    oen_d   = oen_q;
    fsp_d   = tx_edge ? fs_s2_q : fsp_q;
    start   = 1'b0;
    push    = 1'b0;
    rx_take = rx_edge & (st_q == pcs_pkg::PCM_SLOT) & (rxc_q != nbits); // R3
    if (rx_take) begin
      rsh_d = {rsh_q[14:0], dr_s2_q}; // R1 R2
      rxc_d = rxc_q + 5'h01;
      push  = (rxc_q == nbits - 5'h01);
    end
    unique case (st_q)
      pcs_pkg::PCM_IDLE: begin
        // frame opens on the marker's rising edge
        if (tx_edge & fs_s2_q & ~fsp_q) begin // R10
          if (dly) st_d = pcs_pkg::PCM_WAIT; // R7
          else start = 1'b1;
        end
      end
      pcs_pkg::PCM_WAIT: if (tx_edge) start = 1'b1;
      pcs_pkg::PCM_SLOT: begin
        if (tx_edge) begin
          if (cnt_q == nbits - 5'h01) begin
            oen_d = 1'b1; // R9
            st_d  = pcs_pkg::PCM_IDLE;
          end else begin
            dx_d  = tsh_q[14];
            tsh_d = {tsh_q[14:0], 1'b0};
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
    endcase
    // an empty transmit hold sends zeros rather than stale data
    word = txv_q ? txw_q : '0;
    load = lin_q ? {word, 2'h0} : {word[pcs_pkg::CMP_W-1:0], 8'h00}; // R6
    take = start;
    und_set = start & ~txv_q;
    if (start) begin
      st_d  = pcs_pkg::PCM_SLOT;
      cnt_d = 5'h00;
      rxc_d = 5'h00;
      tsh_d = load;
      dx_d  = load[15]; // R9
      oen_d = 1'b0;
    end
    rx_word = lin_q ? rsh_d[15:2] : {6'h00, rsh_d[pcs_pkg::CMP_W-1:0]};
    txv_d = (txv_q & ~take) | (tx_valid_i & txr_q);
    txw_d = (tx_valid_i & txr_q) ? tx_word_i : txw_q;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q  <= pcs_pkg::PCM_IDLE;
      cnt_q <= 5'h00;
      rxc_q <= 5'h00;
      tsh_q <= 16'h0000;
      rsh_q <= 16'h0000;
      dx_q  <= 1'b0;
      oen_q <= 1'b1;
      fsp_q <= 1'b0;
      txv_q <= 1'b0;
      txr_q <= 1'b0;
      txw_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      rxc_q <= rxc_d;
      tsh_q <= tsh_d;
      rsh_q <= rsh_d;
      dx_q  <= dx_d;
      oen_q <= oen_d;
      fsp_q <= fsp_d;
      txv_q <= txv_d;
      txr_q <= ~txv_d;
      txw_q <= txw_d;
    end
  end
  assign transmit_voice_out_o  = dx_q;
  assign transmit_voice_oe_n_o = oen_q;
  assign tx_ready_o            = txr_q;

  // receive buffer: entry 0 is the head, so the outputs are flops
  logic [W-1:0] fm_q [BUF_DEPTH];
  logic [W-1:0] fm_d [BUF_DEPTH];
  logic [BUF_DEPTH-1:0] fv_q, fv_d;
  logic pop, found, ovr_set;
  always_comb begin
    found = 1'b0;
    fm_d  = fm_q;
    fv_d  = fv_q;
    pop   = rx_ready_i & fv_q[0];
    if (pop) begin
      for (int i = 0; i < BUF_DEPTH - 1; i++) begin
        fm_d[i] = fm_q[i+1];
        fv_d[i] = fv_q[i+1];
      end
      fv_d[BUF_DEPTH-1] = 1'b0;
    end
    // line cannot stall, so a word meeting a full buffer is dropped and flagged
    ovr_set = push & fv_q[BUF_DEPTH-1];
    if (push & ~fv_q[BUF_DEPTH-1]) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        if (!fv_d[i] && !found) begin
          fm_d[i] = rx_word;
          fv_d[i] = 1'b1;
          found   = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fv_q <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) fm_q[i] <= '0;
    end else begin
      fv_q <= fv_d;
      fm_q <= fm_d;
    end
  end
  assign rx_word_o  = fm_q[0];
  assign rx_valid_o = fv_q[0];

  // control words arriving from the control clock domain
  logic [15:0] wr_word_q, wr_word_d;
  logic [7:0]  stat_q, stat_d;
  logic        ovr_q, ovr_d, und_q, und_d, wr_evt, wr_cfg;
  logic        cwv_q, cwv_d;
  logic [6:0]  cwa_q, cwa_d;
  logic [7:0]  cwd_q, cwd_d;
  always_comb begin
    wr_evt = wt_s2_q ^ wt_s3_q; // R5
    wr_cfg = wr_evt & (wr_word_q[14:8] == pcs_pkg::CFG_ADDR);
    mode_d = wr_cfg ? wr_word_q[1:0] : mode_q; // R7
    lin_d  = wr_cfg ? wr_word_q[pcs_pkg::CFG_LIN_BIT] : lin_q; // R6
    ovr_d  = ovr_set | (ovr_q & ~wr_cfg);
    und_d  = und_set | (und_q & ~wr_cfg);
    // frozen while selected so the other domain reads a steady byte
    stat_d = cs_s2_q ? {ovr_q, und_q, 3'h0, lin_q, mode_q} : stat_q; // R5
    cwv_d  = wr_evt & ~wr_cfg;
    cwa_d  = wr_evt ? wr_word_q[14:8] : cwa_q;
    cwd_d  = wr_evt ? wr_word_q[7:0] : cwd_q;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= pcs_pkg::CFG_MODE_RST;
      lin_q  <= pcs_pkg::CFG_LIN_RST;
      ovr_q  <= 1'b0;
      und_q  <= 1'b0;
      stat_q <= 8'h00;
      cwv_q  <= 1'b0;
      cwa_q  <= 7'h00;
      cwd_q  <= 8'h00;
    end else begin
      mode_q <= mode_d;
      lin_q  <= lin_d;
      ovr_q  <= ovr_d;
      und_q  <= und_d;
      stat_q <= stat_d;
      cwv_q  <= cwv_d;
      cwa_q  <= cwa_d;
      cwd_q  <= cwd_d;
    end
  end
  assign ctl_wr_valid_o = cwv_q;
  assign ctl_wr_addr_o  = cwa_q;
  assign ctl_wr_data_o  = cwd_q;

  // control clock domain; deselect clears the frame even with no clock running
  logic       ctl_rst_n, cmd_rd;
  logic [4:0] cc_q, cc_d;
  logic [7:0] ish_q, ish_d, cmd_q, cmd_d, osh_q, osh_d;
  logic       wt_d, co_q, co_d;
  assign ctl_rst_n = reset_n_i & ~control_select_n_i; // R8
  assign cmd_rd    = cmd_q[pcs_pkg::CMD_RD_BIT];
  always_comb begin
    cc_d      = (cc_q == pcs_pkg::CTL_DONE) ? cc_q : cc_q + 5'h01; // R4
    ish_d     = {ish_q[6:0], command_serial_in_i}; // R11
    cmd_d     = (cc_q == pcs_pkg::CTL_CMD_END - 5'h01) ? ish_d : cmd_q;
    wt_d      = wt_q;
    wr_word_d = wr_word_q;
    if (cc_q == pcs_pkg::CTL_LAST && !cmd_rd) begin // R4
      wr_word_d = {cmd_q, ish_d};
      wt_d      = ~wt_q;
    end
    co_d  = 1'b0;
    osh_d = {osh_q[6:0], 1'b0};
    if (cmd_rd && cc_q == pcs_pkg::CTL_CMD_END) begin
      co_d  = stat_q[7]; // R12
      osh_d = {stat_q[6:0], 1'b0};
    end else if (cmd_rd && cc_q > pcs_pkg::CTL_CMD_END && cc_q <= pcs_pkg::CTL_LAST) begin
      co_d = osh_q[7]; // R12
    end
  end
  always_ff @(posedge control_clock_i or negedge ctl_rst_n) begin
    if (!ctl_rst_n) begin
      cc_q  <= 5'h00;
      ish_q <= 8'h00;
      cmd_q <= 8'h00;
    end else begin
      cc_q  <= cc_d;
      ish_q <= ish_d;
      cmd_q <= cmd_d;
    end
  end
  // held across deselect; the main domain copies it after the toggle settles
  always_ff @(posedge control_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wt_q      <= 1'b0;
      wr_word_q <= 16'h0000;
    end else begin
      wt_q      <= wt_d;
      wr_word_q <= wr_word_d;
    end
  end
  always_ff @(negedge control_clock_i or negedge ctl_rst_n) begin
    if (!ctl_rst_n) begin
      co_q  <= 1'b0;
      osh_q <= 8'h00;
    end else begin
      co_q  <= co_d;
      osh_q <= osh_d;
    end
  end
  assign status_serial_out_o = co_q;

  chk_rx_fall_edge: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R1
    rx_take && !rev |-> $past(mc_s2_q) && !mc_s2_q) else $error("rx not on falling edge");
  chk_rx_rise_edge: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R2
    rx_take && rev |-> !$past(mc_s2_q) && mc_s2_q) else $error("rx not on rising edge");
  chk_rx_in_slot: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R3
    rx_take |-> !transmit_voice_oe_n_o && rxc_q < nbits) else $error("rx bit taken outside slot");
  chk_tx_float_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R9
    st_q != pcs_pkg::PCM_SLOT |-> transmit_voice_oe_n_o) else $error("tx driven outside slot");
  chk_tx_edge_only: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R9
    $changed(transmit_voice_out_o) |-> $past(tx_edge)) else $error("tx changed off its edge");
  chk_cfg_write: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R7
    wr_cfg |=> mode_q == $past(wr_word_q[1:0]) && lin_q == $past(wr_word_q[pcs_pkg::CFG_LIN_BIT]))
    else $error("config not taken");
  chk_stat_frozen: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R5
    !cs_s2_q && !$past(cs_s2_q) |-> $stable(stat_q)) else $error("status moved while selected");
  chk_ctl_idle: assert property (@(posedge control_clock_i) disable iff (!reset_n_i) // R8
    control_select_n_i |-> cc_q == 5'h00) else $error("control counted while deselected");
  chk_cmd_capture: assert property (@(posedge control_clock_i) disable iff (!ctl_rst_n) // R11
    cc_q == pcs_pkg::CTL_CMD_END - 5'h01 |=> cmd_q == {$past(ish_q[6:0]), $past(command_serial_in_i)})
    else $error("command byte wrong");
  chk_status_shift: assert property (@(negedge control_clock_i) disable iff (!ctl_rst_n) // R12
    cmd_rd && cc_q == pcs_pkg::CTL_CMD_END + 5'h01 |=> co_q == $past(osh_q[7])) else $error("status bit not shifted");
endmodule

// file: test/pcs_far_end.sv
`timescale 1ns/100ps
module pcs_far_end #(
  parameter int HALF_NS = 250,
  parameter int N_PER   = 250
) (
  // framing as the bench configured it
  input  wire logic [1:0]  mode_i,
  input  wire logic        lin_i,
  input  wire logic [15:0] rx_bits_i,
  // device pins
  input  wire logic        tx_i,
  input  wire logic        tx_oe_n_i,
  output logic             mclk_o,
  output logic             frame_marker_o,
  output logic             rx_o,
  // what was seen
  output logic [15:0]      tx_seen_o,
  output logic [7:0]       stray_o
);
  int   k = 0;
  int   j;
  logic rev;
  assign rev = (mode_i == pcs_pkg::MODE_REVERSE);
  // main clock runs free, the filters need it between frames too
  // one process owns every pin of the model, so no output has two drivers
  initial begin
    mclk_o         = 1'b0;
    frame_marker_o = 1'b0;
    rx_o           = 1'b0;
    tx_seen_o      = 16'h0000;
    stray_o        = 8'h00;
    forever begin
      #(HALF_NS) mclk_o = ~mclk_o;
      if (mclk_o ^ rev) begin
        k = (k == N_PER - 1) ? 0 : k + 1;
        if (k == 0) tx_seen_o = 16'h0000;
      end
      j = k - ((mode_i == pcs_pkg::MODE_DELAYED) ? 1 : 0);
      if (mclk_o ^ rev) begin
        // outside the slot the line carries junk, never a held bit
        rx_o = (j >= 0 && j < (lin_i ? 16 : 8)) ? rx_bits_i[15-j] : ~rx_o;
      end else begin
        frame_marker_o = (k == N_PER - 1);
        if (j >= 0 && j < (lin_i ? 16 : 8)) tx_seen_o[15-j] = tx_oe_n_i ? 1'bx : tx_i;
        else if (!tx_oe_n_i) stray_o = stray_o + 8'h01;
      end
    end
  end
endmodule

// file: test/tb_pcs_port.sv
`timescale 1ns/100ps
module tb_pcs_port;
  logic                         clk_i, reset_n_i, mclk, marker, rx_pin, tx_pin, tx_oe_n;
  logic                         control_clock, sel_n, cmd, st_pin, rx_valid, rx_ready, tx_valid, tx_ready;
  logic                         wr_valid, far_lin, l;
  logic [pcs_pkg::SAMPLE_W-1:0] rx_word, tx_word, last_rx, w;
  logic [6:0]                   wr_addr, a;
  logic [7:0]                   wr_data, stray, s0, st, d;
  logic [1:0]                   far_mode, m;
  logic [15:0]                  rx_bits, tx_seen;
  logic [14:0]                  last_wr;
  int                           n_fail, checks_done, seed, i, n0;
  int                           n_pop = 0;

  pcs_port u_pcs_port (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .mclk_i(mclk), .frame_marker_i(marker),
    .receive_voice_in_i(rx_pin), .transmit_voice_out_o(tx_pin), .transmit_voice_oe_n_o(tx_oe_n),
    .control_clock_i(control_clock), .control_select_n_i(sel_n), .command_serial_in_i(cmd),
    .status_serial_out_o(st_pin), .rx_word_o(rx_word), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .tx_word_i(tx_word), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .ctl_wr_valid_o(wr_valid),
    .ctl_wr_addr_o(wr_addr), .ctl_wr_data_o(wr_data));
  pcs_far_end u_pcs_far_end (
    .mode_i(far_mode), .lin_i(far_lin), .rx_bits_i(rx_bits), .tx_i(tx_pin), .tx_oe_n_i(tx_oe_n),
    .mclk_o(mclk), .frame_marker_o(marker), .rx_o(rx_pin), .tx_seen_o(tx_seen), .stray_o(stray));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      last_rx <= rx_word;
      n_pop <= n_pop + 1;
    end
    if (wr_valid === 1'b1) last_wr <= {wr_addr, wr_data};
  end

  function automatic logic [15:0] exp_tx(input logic [13:0] v, input logic lin);
    return lin ? {v, 2'b00} : {v[7:0], 8'h00};
  endfunction
  function automatic logic [13:0] exp_rx(input logic [15:0] b, input logic lin);
    return lin ? b[15:2] : {6'h00, b[15:8]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_level(input logic v);
    for (i = 0; i < 9000 && tx_oe_n !== v; i++) @(negedge clk_i);
    if (i == 9000) begin
      n_fail++;
      conclude();
    end
  endtask
  // a slot is over once the drive enable has fallen and risen again
  task automatic wait_slot();
    wait_level(1'b0);
    wait_level(1'b1);
    repeat (12) @(negedge clk_i);
  endtask
  // msb first; status sampled just before each of the last eight rises, well after its falling-edge change
  task automatic ctl_xfer(input logic en, input logic [15:0] bits, output logic [7:0] sv);
    sel_n = ~en;
    #47;
    for (int b = 15; b >= 0; b--) begin
      cmd = bits[b];
      #62.5;
      if (b < 8) sv[b] = st_pin;
      control_clock = 1'b1;
      #62.5 control_clock = 1'b0;
    end
    #62.5 sel_n = 1'b1;
    #400;
  endtask

  initial begin
    seed = 32'ha3ac;
    n_fail = 0;
    checks_done = 0;
    reset_n_i = 1'b0;
    {control_clock, cmd, tx_valid} = 3'b000;
    sel_n = 1'b1;
    rx_ready = 1'b1;
    tx_word = '0;
    far_mode = pcs_pkg::MODE_NORMAL;
    far_lin = 1'b1;
    rx_bits = 16'h0000;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    @(negedge clk_i);
    check(tx_oe_n, 1'b1);
    check(st_pin, 1'b0);
    ctl_xfer(1'b1, 16'h8000, st);
    check(st[2:0], {pcs_pkg::CFG_LIN_RST, pcs_pkg::CFG_MODE_RST});
    for (int c = 0; c < 6; c++) begin
      m = 2'(c % 3);
      l = 1'(c / 3);
      ctl_xfer(1'b1, {13'h0000, l, m}, st);
      far_mode = m;
      far_lin = l;
      ctl_xfer(1'b1, 16'h8000, st);
      check(st[2:0], {l, m});
      w = 14'($random(seed));
      rx_bits = 16'($random(seed));
      wait_slot();
      for (i = 0; i < 100 && tx_ready !== 1'b1; i++) @(negedge clk_i);
      check(tx_ready, 1'b1);
      if (tx_ready !== 1'b1) conclude();
      tx_word = w;
      tx_valid = 1'b1;
      @(negedge clk_i);
      tx_valid = 1'b0;
      s0 = stray;
      wait_slot();
      check(tx_seen, exp_tx(w, l));
      check(last_rx, exp_rx(rx_bits, l));
      check(stray, s0);
    end
    // stall the consumer: two words held, the third dropped
    rx_ready = 1'b0;
    repeat (3) wait_slot();
    check(rx_valid, 1'b1);
    ctl_xfer(1'b1, 16'h8000, st);
    check(st[7:6], 2'b11);
    n0 = n_pop;
    rx_ready = 1'b1;
    repeat (8) @(negedge clk_i);
    check(16'(n_pop - n0), 16'h0002);
    check(rx_valid, 1'b0);
    ctl_xfer(1'b0, 16'h0001, st);
    ctl_xfer(1'b1, 16'h8000, st);
    check(st[2:0], {1'b1, pcs_pkg::MODE_DELAYED});
    a = 7'($random(seed)) | 7'h01;
    d = 8'($random(seed));
    ctl_xfer(1'b1, {1'b0, a, d}, st);
    check(last_wr, {a, d});
    conclude();
  end
endmodule
